//--- bench/nv_io_expander_core_test.sv
// Self-checking bench of the expander core
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module nv_io_expander_core_test
   import nvio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NPC = 600;
   localparam logic [6:0] DEV = {DEV_ADDR_HIGH, 3'h5};
   logic mclk = 1'b0, lclk = 1'b0, rst_b = 1'b0, fact_b = 1'b0;
   logic [8:0] ext = 9'h1ff, pins = 9'h000;
   logic scl, m_oe, sda_oe, sda_o, busy;
   logic [8:0] io_o, io_oe, io_pu;
   int miscompares = 0, total_checks = 0;
   logic [27:0] rows [8] = '{28'hf055551, 28'hf101011, 28'hf2a5a51, 28'hf301011,
      28'hf53c3c1, 28'h10c3c31, 28'hfa77770, 28'h5099000};
   wire sda = ~(m_oe | sda_oe);
   always #12.5 mclk = ~mclk;
   initial begin
      #3;
      forever #16 lclk = ~lclk;
   end
   always @(posedge mclk) pins <= ext & ~io_oe;
   nvio_expander_core #(.NV_PROG_CYCLES(NPC)) nvio_expander_core_i (
      .mclk_in(mclk), .rst_b_in(rst_b), .nv_factory_b_in(fact_b), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_strap_0_in(1'b1),
      .addr_strap_1_in(1'b0), .addr_strap_2_in(1'b1), .io_in(pins), .io_out(io_o),
      .io_oe_out(io_oe), .io_pullup_en_out(io_pu), .nv_busy_out(busy));
   nvio_master nvio_master_i (.lclk_in(lclk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   task automatic conclude();
      if (miscompares == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic idle_wait();
      for (int i = 0; i < NPC + 100 && busy !== 1'b0; i++) @(posedge mclk);
      `CHK(busy, 1'b0)
   endtask
   task automatic probe(input logic [6:0] a, input logic n);
      logic [8:0] q;
      nvio_master_i.start();
      nvio_master_i.xfer({a, 2'b01}, q);
      `CHK(q[0], n)
      nvio_master_i.stop();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic bz);
      logic [8:0] q;
      idle_wait();
      nvio_master_i.start();
      nvio_master_i.xfer({DEV, 2'b01}, q);
      `CHK(q[0], 1'b0)
      nvio_master_i.xfer({a, 1'b1}, q);
      `CHK(q[0], 1'b0)
      nvio_master_i.xfer({v, 1'b1}, q);
      `CHK(q[0], 1'b0)
      nvio_master_i.stop();
      repeat (20) @(posedge mclk);
      `CHK(busy, bz)
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] q;
      idle_wait();
      nvio_master_i.start();
      nvio_master_i.xfer({DEV, 2'b01}, q);
      nvio_master_i.xfer({a, 1'b1}, q);
      nvio_master_i.start();
      nvio_master_i.xfer({DEV, 2'b11}, q);
      `CHK(q[0], 1'b0)
      nvio_master_i.xfer(9'h1ff, q);
      nvio_master_i.stop();
      d = q[8:1];
   endtask
   initial begin
      #2000000;
      miscompares++;
      conclude();
   end
   initial begin
      logic [7:0] d;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      fact_b <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK(io_oe, ~{RST_DRV_HI[0], RST_DRV_LO})
      `CHK(io_pu, {RST_PU_HI[0], RST_PU_LO})
      foreach (rows[i]) begin
         wr(rows[i][27:20], rows[i][19:12], rows[i][0]);
         rd(rows[i][27:20], d);
         `CHK(d, rows[i][11:4])
      end
      `CHK(io_pu, 9'h155)
      `CHK(io_oe, 9'h05a)
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         ext <= k ? 9'h0c3 : 9'h1ff;
         rd(ADR_LVL_LO, d);
         `CHK(d, k ? 8'h81 : 8'ha5)
         rd(ADR_LVL_HI, d);
         `CHK(d[0], k ? 1'b0 : 1'b1)
      end
      wr(ADR_LVL_LO, 8'h00, 1'b0);
      rd(ADR_LVL_LO, d);
      `CHK(d, 8'h81)
      wr(8'h11, 8'h5a, 1'b1);
      probe(DEV, 1'b1);
      wr(ADR_CFG, 8'h01, 1'b0);
      wr(ADR_DRV_LO, 8'h0f, 1'b0);
      `CHK(io_oe, 9'h0f0)
      rd(ADR_CFG, d);
      `CHK(d, 8'h01)
      probe(DEV ^ 7'h04, 1'b1);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK(io_oe, 9'h05a)
      rd(ADR_CFG, d);
      `CHK(d, RST_CFG)
      conclude();
   end
endmodule
bind nvio_expander_core nvio_chk #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) nvio_chk_i (
   .mclk_in(mclk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .io_out(io_out), .io_oe_out(io_oe_out),
   .io_pullup_en_out(io_pullup_en_out), .nv_busy_out(nv_busy_out));

//--- bench/nvio_chk.sv
// Port-level assertions of the expander core
module nvio_chk
   import nvio_pkg::*;
#(
   parameter int NV_PROG_CYCLES = 50
) (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [NVIO_PINS-1:0] io_out,
   input wire logic [NVIO_PINS-1:0] io_oe_out,
   input wire logic [NVIO_PINS-1:0] io_pullup_en_out,
   input wire logic nv_busy_out
);
   logic scl_q, sda_q, idle_r;
   logic [3:0] fall_cnt, stop_cnt, rel_cnt;
   logic [19:0] busy_cnt;
   wire start_ev = scl_q & scl_in & sda_q & ~sda_in;
   wire stop_ev = scl_q & scl_in & ~sda_q & sda_in;
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         idle_r <= 1'b1;
         fall_cnt <= 4'hf;
         stop_cnt <= 4'hf;
         rel_cnt <= 4'h0;
         busy_cnt <= 20'h0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         idle_r <= stop_ev | (idle_r & ~start_ev);
         fall_cnt <= (scl_q & ~scl_in) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
         stop_cnt <= stop_ev ? 4'h0 : stop_cnt + {3'h0, stop_cnt != 4'hf};
         rel_cnt <= rel_cnt + {3'h0, rel_cnt != 4'hf};
         busy_cnt <= nv_busy_out ? busy_cnt + 20'h1 : 20'h0;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   pin_drive_zero_a: assert property (io_out == '0 && !sda_out)
      else $error("pin or data line driven high");
   busy_after_stop_a: assert property ($rose(nv_busy_out) |-> stop_cnt <= 4'h7)
      else $error("programming began without a stop");
   busy_when_idle_a: assert property ($rose(nv_busy_out) |-> idle_r)
      else $error("programming began with bus not idle");
   busy_length_a: assert property ($fell(nv_busy_out) |-> busy_cnt == 20'(NV_PROG_CYCLES))
      else $error("programming time wrong");
   busy_no_ack_a: assert property (nv_busy_out |-> !sda_oe_out)
      else $error("answer while programming");
   ack_after_fall_a: assert property ($changed(sda_oe_out) |-> fall_cnt <= 4'h7)
      else $error("data line moved outside clock low");
   pins_on_write_a: assert property (($changed(io_oe_out) || $changed(io_pullup_en_out))
      |-> fall_cnt <= 4'h7 || rel_cnt <= 4'h3)
      else $error("pins changed without a write");
   idle_release_a: assert property (idle_r |-> !sda_oe_out)
      else $error("data line pulled on idle bus");
   cover property ($rose(nv_busy_out));
   cover property ($rose(sda_oe_out));
   cover property (start_ev && !idle_r);
endmodule

//--- bench/nvio_master.sv
// Serial bus master model facing the slave port
module nvio_master (
   input wire logic lclk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic step(input logic c, input logic o);
      scl_out <= c;
      sda_oe_out <= o;
      repeat (8) @(posedge lclk_in);
   endtask
   task automatic start();
      step(scl_out, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   task automatic stop();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, ~d[i]);
         step(1'b1, ~d[i]);
         q[i] = sda_in;
         step(1'b1, ~d[i]);
         step(1'b0, ~d[i]);
      end
   endtask
endmodule

//--- rtl/nvio_expander_core.sv
// Nine-pin nonvolatile I/O expander with serial slave port
// Functional notes
// - Nine pins, 64 user bytes via serial port
// - Pin: input, open-drain pulldown, switchable pullup
// - Pullup enables written at F0h, F1h
// - Pulldown drive set at F2h, F3h
// - F8h, F9h read actual pin levels
// - Control and pullup registers read back contents
// - Control registers: working copy plus nonvolatile copy
// - Nonvolatile location write starts programming cycle
// - Shadow-only select is bit 0 at F4h
// - Select 0: write both copies, program
// - Select 1: working copy only, no programming
// - Strap low gives 0, high gives 1
// - SDA falling, SCL high: start
// - SDA rising, SCL high: stop
// - Repeated start begins new transfer
// - Data bits captured on SCL rising edge
// - Bus idle between stop and start
// - Pullup bit n for pin n, 1 enables
// - Control 0 drives low, 1 releases; pin8 bit0
// - F9h only bit 0 meaningful; status writes ignored
// - Programming time begins after ending stop
module nvio_expander_core
   import nvio_pkg::*;
#(
   parameter int NV_PROG_CYCLES = NV_PROGRAM_CYCLES
) (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic nv_factory_b_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic addr_strap_0_in,
   input wire logic addr_strap_1_in,
   input wire logic addr_strap_2_in,
   input wire logic [NVIO_PINS-1:0] io_in,
   output logic [NVIO_PINS-1:0] io_out,
   output logic [NVIO_PINS-1:0] io_oe_out,
   output logic [NVIO_PINS-1:0] io_pullup_en_out,
   output logic nv_busy_out
);

   // Link side: bit capture on the master's clock
   logic bit_data_r;

   always_ff @(posedge scl_in) begin
      bit_data_r <= sda_in;
   end

   // Synchronisers
   logic scl_s1_r, scl_s2_r, scl_s3_r;
   logic sda_s1_r, sda_s2_r, sda_s3_r;
   logic [2:0] strap_s1_r, strap_s2_r;
   logic [NVIO_PINS-1:0] io_s1_r, io_s2_r;

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
         io_s1_r <= '0;
         io_s2_r <= '0;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
         io_s1_r <= io_in;
         io_s2_r <= io_s1_r;
      end
   end

   // Straps settle through reset, valid when latched
   always_ff @(posedge mclk_in) begin
      strap_s1_r <= {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
      strap_s2_r <= strap_s1_r;
   end

   // Bus events
   nvio_bus_evt_s evt;

   always_comb begin
      evt.start = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
      evt.stop = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
      evt.rise = scl_s2_r && !scl_s3_r;
      evt.fall = !scl_s2_r && scl_s3_r;
   end

   // Storage
   nvio_pin_cfg_s sram_r;
   nvio_pin_cfg_s ee_r;
   logic [7:0] cfg_r;
   logic [7:0] user_mem_r [NVIO_USER_BYTES];
   logic [7:0] aux_mem_r [NVIO_AUX_BYTES];
   logic loaded_r;
   logic [2:0] strap_r;

   // Protocol state
   nvio_state_e state_r;
   logic [3:0] cnt_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic [7:0] ptr_r;
   logic rw_r;
   logic mack_r;
   logic nv_pend_r;
   logic [NV_CNT_W-1:0] busy_cnt_r;
   logic busy_r;
   logic [7:0] rd_data;
   logic wr_stb;
   logic byte_end;
   logic see;

   function automatic logic is_user_ee(input logic [7:0] a);
      return (a <= ADR_USER_LAST) || (a >= ADR_UEE_FIRST && a <= ADR_UEE_LAST);
   endfunction

   function automatic logic is_shadowed(input logic [7:0] a);
      return a >= ADR_PU_LO && a <= ADR_DRV_HI;
   endfunction

   assign see = cfg_r[CFG_SHADOW_ONLY_BIT];
   assign byte_end = evt.fall && (cnt_r == BITS_PER_BYTE);
   assign wr_stb = byte_end && (state_r == ST_WDAT);

   // Read data, pin levels taken as the byte is loaded
   always_comb begin
      rd_data = 8'h00;
      if (ptr_r <= ADR_USER_LAST) begin
         rd_data = user_mem_r[ptr_r[5:0]];
      end else begin
         unique case (ptr_r)
            ADR_PU_LO: rd_data = sram_r.pu_lo;
            ADR_PU_HI: rd_data = sram_r.pu_hi;
            ADR_DRV_LO: rd_data = sram_r.drv_lo;
            ADR_DRV_HI: rd_data = sram_r.drv_hi;
            ADR_CFG: rd_data = cfg_r;
            ADR_LVL_LO: rd_data = io_s2_r[7:0];
            ADR_LVL_HI: rd_data = {7'h00, io_s2_r[8]};
            default: begin
               if (ptr_r >= ADR_UEE_FIRST) begin
                  rd_data = aux_mem_r[ptr_r[3:0]];
               end
            end
         endcase
      end
   end

   // Nonvolatile copies survive the functional reset
   always_ff @(posedge mclk_in) begin
      if (!nv_factory_b_in) begin
         ee_r <= {RST_PU_LO, RST_PU_HI, RST_DRV_LO, RST_DRV_HI};
      end else if (wr_stb && !see) begin
         unique case (ptr_r)
            ADR_PU_LO: ee_r.pu_lo <= rx_r;
            ADR_PU_HI: ee_r.pu_hi <= rx_r;
            ADR_DRV_LO: ee_r.drv_lo <= rx_r;
            ADR_DRV_HI: ee_r.drv_hi <= rx_r;
            default: ;
         endcase
      end
   end

   // Nonvolatile user bytes
   always_ff @(posedge mclk_in) begin
      if (!nv_factory_b_in) begin
         for (int i = 0; i < NVIO_USER_BYTES; i++) begin
            user_mem_r[i] <= RST_USER;
         end
      end else if (wr_stb && ptr_r <= ADR_USER_LAST) begin
         user_mem_r[ptr_r[5:0]] <= rx_r;
      end
   end

   // Upper user bytes
   always_ff @(posedge mclk_in) begin
      if (!nv_factory_b_in) begin
         for (int i = 0; i < NVIO_AUX_BYTES; i++) begin
            aux_mem_r[i] <= RST_USER;
         end
      end else if (wr_stb && (is_user_ee(ptr_r) || ptr_r >= ADR_URAM_FIRST)) begin
         if (ptr_r > ADR_USER_LAST) begin
            aux_mem_r[ptr_r[3:0]] <= rx_r;
         end
      end
   end

   // Working copies, loaded once after reset
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         sram_r <= {RST_PU_LO, RST_PU_HI, RST_DRV_LO, RST_DRV_HI};
         cfg_r <= RST_CFG;
         loaded_r <= 1'b0;
         strap_r <= 3'h0;
      end else if (!loaded_r) begin
         sram_r <= ee_r;
         loaded_r <= 1'b1;
         strap_r <= strap_s2_r;
      end else if (wr_stb) begin
         unique case (ptr_r)
            ADR_PU_LO: sram_r.pu_lo <= rx_r;
            ADR_PU_HI: sram_r.pu_hi <= rx_r;
            ADR_DRV_LO: sram_r.drv_lo <= rx_r;
            ADR_DRV_HI: sram_r.drv_hi <= rx_r;
            ADR_CFG: cfg_r <= rx_r;
            default: ;
         endcase
      end
   end

   // Pin drivers
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         io_out <= '0;
         io_oe_out <= '0;
         io_pullup_en_out <= '0;
      end else begin
         io_out <= '0;
         if (loaded_r) begin
            io_oe_out <= ~{sram_r.drv_hi[0], sram_r.drv_lo};
            io_pullup_en_out <= {sram_r.pu_hi[0], sram_r.pu_lo};
         end
      end
   end

   // Programming cycle timer
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         nv_pend_r <= 1'b0;
         busy_r <= 1'b0;
         busy_cnt_r <= '0;
      end else begin
         if (wr_stb && (is_user_ee(ptr_r) || (is_shadowed(ptr_r) && !see))) begin
            nv_pend_r <= 1'b1;
         end else if (evt.stop || evt.start) begin
            nv_pend_r <= 1'b0;
         end
         if (evt.stop && nv_pend_r) begin
            busy_r <= 1'b1;
            busy_cnt_r <= NV_CNT_W'(NV_PROG_CYCLES - 1);
         end else if (busy_r) begin
            if (busy_cnt_r == '0) begin
               busy_r <= 1'b0;
            end else begin
               busy_cnt_r <= busy_cnt_r - 1'b1;
            end
         end
      end
   end

   assign nv_busy_out = busy_r;

   // Serial slave sequencer
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         mack_r <= 1'b1;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
      end else if (evt.start) begin
         state_r <= ST_DEV;
         cnt_r <= 4'h0;
         sda_oe_out <= 1'b0;
      end else if (evt.stop) begin
         state_r <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else if (evt.rise) begin
         if (state_r == ST_RACK) begin
            mack_r <= bit_data_r;
         end else if (state_r != ST_IDLE && state_r != ST_DACK && state_r != ST_WACK) begin
            rx_r <= {rx_r[6:0], bit_data_r};
            cnt_r <= cnt_r + 1'b1;
         end
      end else if (evt.fall) begin
         unique case (state_r)
            ST_IDLE: ;
            ST_DEV: begin
               if (cnt_r == BITS_PER_BYTE) begin
                  if (rx_r[7:1] == {DEV_ADDR_HIGH, strap_r} && !busy_r) begin
                     rw_r <= rx_r[0];
                     sda_oe_out <= 1'b1;
                     state_r <= ST_DACK;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_DACK: begin
               cnt_r <= 4'h0;
               if (rw_r) begin
                  tx_r <= rd_data;
                  sda_oe_out <= !rd_data[7];
                  state_r <= ST_RDAT;
               end else begin
                  sda_oe_out <= 1'b0;
                  state_r <= ST_WADR;
               end
            end
            ST_WADR: begin
               if (byte_end) begin
                  ptr_r <= rx_r;
                  sda_oe_out <= 1'b1;
                  state_r <= ST_WACK;
               end
            end
            ST_WACK: begin
               cnt_r <= 4'h0;
               sda_oe_out <= 1'b0;
               state_r <= ST_WDAT;
            end
            ST_WDAT: begin
               if (byte_end) begin
                  ptr_r <= ptr_r + 1'b1;
                  sda_oe_out <= 1'b1;
                  state_r <= ST_WACK;
               end
            end
            ST_RDAT: begin
               if (byte_end) begin
                  sda_oe_out <= 1'b0;
                  ptr_r <= ptr_r + 1'b1;
                  state_r <= ST_RACK;
               end else begin
                  sda_oe_out <= !tx_r[3'd7 - cnt_r[2:0]];
               end
            end
            ST_RACK: begin
               cnt_r <= 4'h0;
               if (!mack_r) begin
                  tx_r <= rd_data;
                  sda_oe_out <= !rd_data[7];
                  state_r <= ST_RDAT;
               end else begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

//--- rtl/nvio_pkg.sv
// Constants, types and state codes of the nonvolatile I/O expander core
package nvio_pkg;
   localparam int NVIO_PINS = 9;
   localparam int NVIO_USER_BYTES = 64;
   localparam int NVIO_AUX_BYTES = 16;
   localparam logic [7:0] ADR_USER_LAST = 8'h3f;
   localparam logic [7:0] ADR_PU_LO = 8'hf0;
   localparam logic [7:0] ADR_PU_HI = 8'hf1;
   localparam logic [7:0] ADR_DRV_LO = 8'hf2;
   localparam logic [7:0] ADR_DRV_HI = 8'hf3;
   localparam logic [7:0] ADR_CFG = 8'hf4;
   localparam logic [7:0] ADR_UEE_FIRST = 8'hf5;
   localparam logic [7:0] ADR_UEE_LAST = 8'hf7;
   localparam logic [7:0] ADR_LVL_LO = 8'hf8;
   localparam logic [7:0] ADR_LVL_HI = 8'hf9;
   localparam logic [7:0] ADR_URAM_FIRST = 8'hfa;
   localparam int CFG_SHADOW_ONLY_BIT = 0;
   localparam logic [7:0] RST_PU_LO = 8'h00;
   localparam logic [7:0] RST_PU_HI = 8'h00;
   localparam logic [7:0] RST_DRV_LO = 8'hff;
   localparam logic [7:0] RST_DRV_HI = 8'h01;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_USER = 8'h00;
   // Arbitrary upper nibble of the slave address
   localparam logic [3:0] DEV_ADDR_HIGH = 4'ha;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int NV_PROGRAM_TIME_US = 20000;
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int NV_PROGRAM_CYCLES = NV_PROGRAM_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int NV_CNT_W = 20;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEV = 3'h1,
      ST_DACK = 3'h3,
      ST_WADR = 3'h2,
      ST_WACK = 3'h6,
      ST_WDAT = 3'h7,
      ST_RDAT = 3'h5,
      ST_RACK = 3'h4
   } nvio_state_e;

   typedef struct packed {
      logic [7:0] pu_lo;
      logic [7:0] pu_hi;
      logic [7:0] drv_lo;
      logic [7:0] drv_hi;
   } nvio_pin_cfg_s;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } nvio_bus_evt_s;
endpackage
